// [src/disc_pkg.sv]
// constants, timing counts and state codes for the daisy-chain discovery slave
// assumes a single 25 MHz clock; every time below is converted to whole cycles here
package disc_pkg;
    // clock period and timing figures; the times are plain choices
    localparam int unsigned CLK_PERIOD_NS      = 40;
    localparam int unsigned DISC_START_TIME_US = 1000;
    localparam int unsigned DISC_PERIOD_US     = 500;
    localparam int unsigned DISC_WINDOW_END_US = 20000;
    localparam int unsigned RSP_DELAY_US       = 20;
    localparam int unsigned RAMP_TIME_US       = 40;
    localparam int unsigned HOLD_TIME_US       = 40;

    // least times round up, longest times round down, never below one cycle
    function automatic int unsigned cyc_min(input int unsigned us);
        int unsigned c;
        c = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    function automatic int unsigned cyc_max(input int unsigned us);
        int unsigned c;
        c = (us * 1000) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_max

    // long counts, used as top-level parameter defaults
    localparam int unsigned DISC_START_CYC = cyc_min(DISC_START_TIME_US);
    localparam int unsigned DISC_PERIOD_CYC = cyc_min(DISC_PERIOD_US);
    localparam int unsigned DISC_WINDOW_CYC = cyc_max(DISC_WINDOW_END_US);

    // short phase counts of one discovery round
    localparam int unsigned PHASE_W = 12;
    localparam logic [PHASE_W-1:0] RSP_DELAY_CYC = PHASE_W'(cyc_min(RSP_DELAY_US));
    localparam logic [PHASE_W-1:0] RAMP_CYC      = PHASE_W'(cyc_max(RAMP_TIME_US));
    localparam logic [PHASE_W-1:0] HOLD_CYC      = PHASE_W'(cyc_min(HOLD_TIME_US));

    // timer and address widths
    localparam int unsigned TIMER_W = 20;
    localparam int unsigned ADDR_W  = 4;
    localparam logic [ADDR_W-1:0] ADDR_NONE  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_LAST  = 4'hF;

    // command frame layout, first bit received lands in bit 31
    localparam int unsigned FRAME_BITS = 32;
    localparam logic [5:0]  FRAME_LAST = 6'h1F;
    localparam logic [5:0]  FRAME_FULL = 6'h20;
    localparam int unsigned FA_MSB = 31;
    localparam int unsigned FA_LSB = 28;
    localparam int unsigned FC_MSB = 27;
    localparam int unsigned FC_LSB = 24;
    localparam int unsigned FD_MSB = 23;
    localparam int unsigned FD_LSB = 8;

    // frame check: x^8+x^5+x^3+x^2+x+1, all-ones seed
    localparam int unsigned CRC_W = 8;
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h2F;
    localparam logic [CRC_W-1:0] CRC_SEED = 8'hFF;

    // discovery round states, gray along wait-delay-ramp-hold-addressed
    typedef enum logic [2:0] {
        ST_WAIT  = 3'h0,
        ST_DELAY = 3'h1,
        ST_RAMP  = 3'h3,
        ST_HOLD  = 3'h2,
        ST_ADDR  = 3'h6
    } disc_state_t;
endpackage : disc_pkg

// [src/frame_crc_check.sv]
// serial frame check register for incoming command frames
// assumes bits arrive msb first, one per bitValid, and clear marks a new frame
module frame_crc_check
    import disc_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // serial bit stream
    input  wire logic             clear,
    input  wire logic             bitValid,
    input  wire logic             bitIn,
    // residue, zero after a good frame
    output logic [disc_pkg::CRC_W-1:0] residue
);
    import disc_pkg::*;

    logic [CRC_W-1:0] crc_q;
    logic [CRC_W-1:0] crc_d;
    wire              feedBack = crc_q[CRC_W-1];

    // shift each bit into the low end, fold the polynomial on carry-out
    assign crc_d = {crc_q[CRC_W-2:0], bitIn} ^ (feedBack ? CRC_POLY : '0);
    assign residue = crc_q;

    // seed preset at reset and at each new frame
    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            crc_q <= CRC_SEED;
        end else if (bitValid) begin
            crc_q <= crc_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_crc_seed_load: assert property (clear |=> crc_q == CRC_SEED)
        else $error("frame check register not seeded on frame start");
endmodule : frame_crc_check

// [src/daisy_chain_discovery_addressing.sv]
// slave discovery address assignment and command frame intake
// assumes the analogue front end gives a discovery strobe, a sense comparator
// and a serial bit stream; all inputs are synchronous to ref_clk
module daisy_chain_discovery_addressing
    import disc_pkg::*;
#(
    parameter int unsigned START_CYC  = DISC_START_CYC,
    parameter int unsigned PERIOD_CYC = DISC_PERIOD_CYC,
    parameter int unsigned WINDOW_CYC = DISC_WINDOW_CYC
) (
    // clock and power-on reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // configuration state held elsewhere in the slave
    input  wire logic                   initDoneLock,
    input  wire logic [disc_pkg::ADDR_W-1:0] physAddrOtp,
    // discovery front end
    input  wire logic                   discCmdStrobe,
    input  wire logic                   senseAboveNominal,
    // command receiver bit stream
    input  wire logic                   frameStart,
    input  wire logic                   bitValid,
    input  wire logic                   bitIn,
    // response current control
    output logic                        respCurrentEn,
    output logic                        rampActive,
    output logic                        holdFull,
    // address state
    output logic                        addrAssigned,
    output logic [disc_pkg::ADDR_W-1:0] physAddress,
    // decoded command
    output logic                        cmdValid,
    output logic [3:0]                  cmdCode,
    output logic [15:0]                 cmdData,
    output logic                        cmdCrcError
);
    import disc_pkg::*;

    disc_state_t         state_q;
    disc_state_t         state_d;
    logic [PHASE_W-1:0]  phase_q;
    logic [TIMER_W-1:0]  porCnt_q;
    logic [TIMER_W-1:0]  sinceCmd_q;
    logic                seenCmd_q;
    logic [ADDR_W-1:0]   discCnt_q;
    logic [ADDR_W-1:0]   discAddr_q;
    logic                respCurrentEn_q;
    logic                rampActive_q;
    logic                holdFull_q;
    logic                addrAssigned_q;
    logic [ADDR_W-1:0]   physAddress_q;
    logic [FRAME_BITS-1:0] frame_q;
    logic [5:0]          bitCnt_q;
    logic                frameDone_q;
    logic                cmdValid_q;
    logic [3:0]          cmdCode_q;
    logic [15:0]         cmdData_q;
    logic                cmdCrcError_q;
    logic [CRC_W-1:0]    residue;
    logic [PHASE_W-1:0]  delaySeen_q;

    // stored address: a preset value wins, else what discovery found
    wire [ADDR_W-1:0] storedAddr = (physAddrOtp != ADDR_NONE) ? physAddrOtp : discAddr_q;
    wire eligible   = !initDoneLock && (storedAddr == ADDR_NONE);
    wire windowOpen = (porCnt_q >= TIMER_W'(START_CYC))
                   && (porCnt_q <  TIMER_W'(WINDOW_CYC));
    wire periodOk   = !seenCmd_q || (sinceCmd_q >= TIMER_W'(PERIOD_CYC));
    wire discAccept = discCmdStrobe && eligible && windowOpen && periodOk
                   && (state_q == ST_WAIT);
    wire inRound    = (state_q == ST_RAMP) || (state_q == ST_HOLD);
    wire backOff    = inRound && senseAboveNominal;
    wire delayEnd   = (state_q == ST_DELAY) && (phase_q == RSP_DELAY_CYC - 1'b1);
    wire rampEnd    = (state_q == ST_RAMP) && (phase_q == RAMP_CYC - 1'b1);
    wire holdEnd    = (state_q == ST_HOLD) && (phase_q == HOLD_CYC - 1'b1);
    wire adopt      = holdEnd && !senseAboveNominal;
    wire phaseClr   = discAccept || delayEnd || rampEnd || backOff || adopt;
    wire [ADDR_W-1:0] cntNext = (discCnt_q == ADDR_LAST) ? ADDR_LAST : discCnt_q + 1'b1;

    // round sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_WAIT: begin
                if (discAccept) state_d = ST_DELAY;
            end
            ST_DELAY: begin
                if (delayEnd) state_d = ST_RAMP;
            end
            ST_RAMP: begin
                if (backOff) state_d = ST_WAIT;
                else if (rampEnd) state_d = ST_HOLD;
            end
            ST_HOLD: begin
                if (backOff) state_d = ST_WAIT;
                else if (adopt) state_d = ST_ADDR;
            end
            ST_ADDR: begin
                state_d = ST_ADDR;
            end
            default: state_d = ST_WAIT;
        endcase
    end

    // state and phase counter; the phase restarts on every transition
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= ST_WAIT;
            phase_q <= '0;
        end else begin
            state_q <= state_d;
            phase_q <= phaseClr ? '0 : phase_q + 1'b1;
        end
    end

    // time since power-on and since the last accepted command, both saturate
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            porCnt_q   <= '0;
            sinceCmd_q <= '0;
            seenCmd_q  <= 1'b0;
        end else begin
            if (porCnt_q != '1) porCnt_q <= porCnt_q + 1'b1;
            if (discAccept) begin
                sinceCmd_q <= '0;
                seenCmd_q  <= 1'b1;
            end else if (sinceCmd_q != '1) begin
                sinceCmd_q <= sinceCmd_q + 1'b1;
            end
        end
    end

    // counter starts at one and bumps when someone downstream still draws
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            discCnt_q  <= ADDR_FIRST;
            discAddr_q <= ADDR_NONE;
        end else begin
            if (backOff) discCnt_q <= cntNext;
            if (adopt) discAddr_q <= discCnt_q;
        end
    end

    // current drive follows the next state so it changes with it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            respCurrentEn_q <= 1'b0;
            rampActive_q    <= 1'b0;
            holdFull_q      <= 1'b0;
            addrAssigned_q  <= 1'b0;
            physAddress_q   <= ADDR_NONE;
        end else begin
            respCurrentEn_q <= (state_d == ST_RAMP) || (state_d == ST_HOLD);
            rampActive_q    <= (state_d == ST_RAMP);
            holdFull_q      <= (state_d == ST_HOLD);
            addrAssigned_q  <= (state_d == ST_ADDR) || (physAddrOtp != ADDR_NONE);
            physAddress_q   <= adopt ? discCnt_q : storedAddr;
        end
    end

    // frame shift register; bits past the thirty-second are ignored
    always_ff @(posedge ref_clk) begin
        if (sys_rst || frameStart) begin
            frame_q  <= '0;
            bitCnt_q <= '0;
        end else if (bitValid && bitCnt_q != FRAME_FULL) begin
            frame_q  <= {frame_q[FRAME_BITS-2:0], bitIn};
            bitCnt_q <= bitCnt_q + 1'b1;
        end
    end

    // the check register sees exactly the bits the shift register accepts
    wire crcBitValid = bitValid && (bitCnt_q != FRAME_FULL) && !frameStart;

    frame_crc_check frame_crc_check_inst (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clear    (frameStart),
        .bitValid (crcBitValid),
        .bitIn    (bitIn),
        .residue  (residue)
    );

    // one frame done pulse, the cycle after the last of 32 bits
    wire lastBit  = bitValid && !frameStart && (bitCnt_q == FRAME_LAST);
    wire crcOk    = (residue == '0);
    wire addrHit  = (frame_q[FA_MSB:FA_LSB] == storedAddr);
    wire takeCmd  = frameDone_q && crcOk && addrHit;
    wire dropCrc  = frameDone_q && !crcOk;

    // command outputs; a bad check gives no command, only an error pulse
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frameDone_q   <= 1'b0;
            cmdValid_q    <= 1'b0;
            cmdCrcError_q <= 1'b0;
            cmdCode_q     <= '0;
            cmdData_q     <= '0;
        end else begin
            frameDone_q   <= lastBit;
            cmdValid_q    <= takeCmd;
            cmdCrcError_q <= dropCrc;
            if (takeCmd) begin
                cmdCode_q <= frame_q[FC_MSB:FC_LSB];
                cmdData_q <= frame_q[FD_MSB:FD_LSB];
            end
        end
    end

    // outputs come straight from the flops above
    assign respCurrentEn = respCurrentEn_q;
    assign rampActive    = rampActive_q;
    assign holdFull      = holdFull_q;
    assign addrAssigned  = addrAssigned_q;
    assign physAddress   = physAddress_q;
    assign cmdValid      = cmdValid_q;
    assign cmdCode       = cmdCode_q;
    assign cmdData       = cmdData_q;
    assign cmdCrcError   = cmdCrcError_q;

    // checking aid: cycles spent in the response delay, kept apart from phase_q
    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_q != ST_DELAY) begin
            delaySeen_q <= '0;
        end else begin
            delaySeen_q <= delaySeen_q + 1'b1;
        end
    end

    // assertions below use long spans only through counters, never long delays
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_lock_blocks_disc: assert property (
        (state_q == ST_WAIT && (initDoneLock || physAddrOtp != ADDR_NONE))
            |=> state_q != ST_DELAY)
        else $error("discovery started while locked or preset");
    a_window_gate: assert property (
        (state_q == ST_WAIT) ##1 (state_q == ST_DELAY)
            |-> $past(porCnt_q) >= TIMER_W'(START_CYC))
        else $error("discovery command taken before start time");
    a_delay_to_ramp: assert property (
        $rose(respCurrentEn_q) |-> state_q == ST_RAMP && $past(state_q) == ST_DELAY
            && $past(delaySeen_q) == RSP_DELAY_CYC - 1'b1)
        else $error("ramp did not begin after response delay");
    a_delay_quiet: assert property (
        (state_q == ST_DELAY) |-> !respCurrentEn_q)
        else $error("response current on during response delay");
    a_sense_in_delay: assert property (
        (state_q == ST_DELAY && senseAboveNominal) |=> discCnt_q == $past(discCnt_q))
        else $error("counter moved on sense before the ramp");
    a_backoff_count: assert property (
        (backOff && discCnt_q != ADDR_LAST)
            |=> state_q == ST_WAIT && !respCurrentEn_q
                && discCnt_q == $past(discCnt_q) + 1'b1)
        else $error("sense back-off did not stop current or bump counter");
    a_ramp_to_hold: assert property (
        (rampEnd && !senseAboveNominal) |=> holdFull_q && respCurrentEn_q)
        else $error("quiet ramp did not reach hold level");
    a_first_is_one: assert property (
        (adopt && discCnt_q == ADDR_FIRST)
            |=> physAddress_q == ADDR_FIRST && !respCurrentEn_q && addrAssigned_q)
        else $error("first quiet round did not take address one");
    a_adopt_counter: assert property (
        adopt |=> physAddress_q == $past(discCnt_q) ##1 state_q == ST_ADDR)
        else $error("address not taken from counter");
    a_addr_from_round: assert property (
        ($rose(addrAssigned_q) && physAddrOtp == ADDR_NONE) |-> $past(state_q) == ST_HOLD)
        else $error("address appeared without a discovery round");
    a_frame_length: assert property (
        frameDone_q |-> bitCnt_q == FRAME_FULL)
        else $error("frame completed at wrong bit count");
    a_crc_drops_cmd: assert property (
        dropCrc |=> !cmdValid_q && cmdCrcError_q)
        else $error("command with bad check not discarded");
    a_addr_match: assert property (
        cmdValid_q |-> $past(frame_q[FA_MSB:FA_LSB]) == $past(storedAddr))
        else $error("command taken for another address");

    c_backoff_round: cover property (backOff ##[1:400] discCmdStrobe);
    c_preset_address: cover property ($rose(addrAssigned_q) && physAddrOtp != ADDR_NONE);
    c_take_address: cover property (adopt ##1 addrAssigned_q);
    c_good_command: cover property (cmdValid_q);
    c_bad_check: cover property (cmdCrcError_q);
endmodule : daisy_chain_discovery_addressing

// [verif/dsi_master_model.sv]
// behavioural bus master: discovery command pulses and serial command frames
// assumes one rising-edge clock shared with the slave; the bench calls its tasks
module dsi_master_model (
    // clock
    input  wire logic ref_clk,
    // towards the slave
    output logic      discCmdStrobe,
    output logic      frameStart,
    output logic      bitValid,
    output logic      bitIn
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy = 1'b0;

    initial begin
        discCmdStrobe = 1'b0;
        frameStart    = 1'b0;
        bitValid      = 1'b0;
        bitIn         = 1'b0;
    end

    // idle data line toggles so a stale bit never passes for a held one
    always @(posedge ref_clk) begin
        if (!busy) begin
            bitIn <= ~bitIn;
        end
    end

    // one command pulse; the slave takes it at the edge after launch
    task automatic disc_cmd();
        @(posedge ref_clk);
        discCmdStrobe <= 1'b1;
        @(posedge ref_clk);
        discCmdStrobe <= 1'b0;
    endtask : disc_cmd

    // start pulse, then exactly 32 bits msb first, one per cycle
    task automatic send_frame(input logic [31:0] f);
        busy = 1'b1;
        @(posedge ref_clk);
        frameStart <= 1'b1;
        for (int i = 31; i >= 0; i--) begin
            @(posedge ref_clk);
            frameStart <= 1'b0;
            bitValid   <= 1'b1;
            bitIn      <= f[i];
        end
        @(posedge ref_clk);
        bitValid <= 1'b0;
        @(negedge ref_clk);
        busy = 1'b0;
    endtask : send_frame
endmodule : dsi_master_model

// [verif/tb_daisy_chain_discovery_addressing.sv]
// self-checking bench for the discovery slave with a master model in front
// assumes shortened start, period and window counts; sense is driven here
module tb_daisy_chain_discovery_addressing;
    timeunit 1ns;
    timeprecision 1ps;
    import disc_pkg::*;

    localparam int unsigned P_START  = 20;
    localparam int unsigned P_PERIOD = 2600;
    localparam int unsigned P_WINDOW = 60000;
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              initDoneLock = 1'b0;
    logic [ADDR_W-1:0] physAddrOtp = 4'h0;
    logic              senseAboveNominal = 1'b0;
    logic              discCmdStrobe, frameStart, bitValid, bitIn;
    logic              respCurrentEn, rampActive, holdFull, addrAssigned;
    logic              cmdValid, cmdCrcError, addrSeen;
    logic [ADDR_W-1:0] physAddress;
    logic [3:0]        cmdCode;
    logic [15:0]       cmdData;
    logic [21:0]       notes[$];
    int                n_mismatch = 0;
    int                n_compared = 0;

    always #20 ref_clk = ~ref_clk;

    dsi_master_model dsi_master_model_inst (.ref_clk(ref_clk), .discCmdStrobe(discCmdStrobe),
        .frameStart(frameStart), .bitValid(bitValid), .bitIn(bitIn));

    daisy_chain_discovery_addressing #(.START_CYC(P_START), .PERIOD_CYC(P_PERIOD),
        .WINDOW_CYC(P_WINDOW)) daisy_chain_discovery_addressing_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .initDoneLock(initDoneLock),
        .physAddrOtp(physAddrOtp), .discCmdStrobe(discCmdStrobe),
        .senseAboveNominal(senseAboveNominal), .frameStart(frameStart),
        .bitValid(bitValid), .bitIn(bitIn), .respCurrentEn(respCurrentEn),
        .rampActive(rampActive), .holdFull(holdFull), .addrAssigned(addrAssigned),
        .physAddress(physAddress), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdData(cmdData), .cmdCrcError(cmdCrcError));

    task automatic check(input logic [21:0] got, input logic [21:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // bench-side frame builder: seed all ones, check byte from eight zero shifts
    function automatic logic [31:0] mk_frame(input logic [3:0] a, input logic [3:0] c,
                                             input logic [15:0] d);
        logic [7:0]  r;
        logic [23:0] m;
        r = 8'hFF;
        m = {a, c, d};
        for (int i = 31; i >= 0; i--) begin
            r = {r[6:0], (i >= 8) ? m[i-8] : 1'b0} ^ (r[7] ? 8'h2F : 8'h00);
        end
        return {m, r};
    endfunction : mk_frame

    // result watcher: every pulse or fresh address consumes the oldest note
    always @(negedge ref_clk) begin
        if (cmdValid === 1'b1 || cmdCrcError === 1'b1) begin
            check({1'b0, cmdCrcError, cmdValid ? {cmdCode, cmdData} : 20'h0},
                  (notes.size() != 0) ? notes.pop_front() : 22'h3FFFFF);
        end
        if (addrAssigned === 1'b1 && addrSeen !== 1'b1) begin
            check({2'b10, 16'h0, physAddress},
                  (notes.size() != 0) ? notes.pop_front() : 22'h3FFFFF);
        end
        addrSeen = addrAssigned;
    end

    // reset with a preset address and lock level; outputs quiet while held
    task automatic do_reset(input logic [3:0] p, input logic l);
        @(posedge ref_clk);
        physAddrOtp  <= p;
        initDoneLock <= l;
        sys_rst      <= 1'b1;
        repeat (1) @(posedge ref_clk);
        @(negedge ref_clk);
        check(22'({respCurrentEn, rampActive, holdFull, addrAssigned, cmdValid}), 22'h0);
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        if (p != 4'h0) notes.push_back({2'b10, 16'h0, p});
        repeat (P_START + 2) @(posedge ref_clk);
    endtask : do_reset

    // random command and data; a bad frame has its last check bit flipped
    task automatic frame(input logic [3:0] a, input logic good, input logic heard);
        logic [3:0]  c;
        logic [15:0] d;
        c = 4'($urandom);
        d = 16'($urandom);
        if (heard) notes.push_back(good ? {2'b00, c, d} : 22'h100000);
        dsi_master_model_inst.send_frame(mk_frame(a, c, d) ^ {31'h0, !good});
        repeat (4) @(posedge ref_clk);
    endtask : frame

    // one round; sense is high early on, where the slave must still ignore it
    task automatic round(input logic [3:0] adr, input logic down, input logic taken);
        if (taken && !down) notes.push_back({2'b10, 16'h0, adr});
        @(posedge ref_clk);
        senseAboveNominal <= 1'b1;
        dsi_master_model_inst.disc_cmd();
        repeat (100) @(posedge ref_clk);
        senseAboveNominal <= 1'b0;
        repeat (399) @(posedge ref_clk);
        @(negedge ref_clk);
        check(22'(rampActive), 22'h0);
        @(negedge ref_clk);
        check(22'({respCurrentEn, rampActive}), taken ? 22'h3 : 22'h0);
        if (down) begin
            @(posedge ref_clk);
            senseAboveNominal <= 1'b1;
            @(posedge ref_clk);
            senseAboveNominal <= 1'b0;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            check(22'({respCurrentEn, rampActive, holdFull, addrAssigned}), 22'h0);
        end else begin
            repeat (1000) @(posedge ref_clk);
            @(negedge ref_clk);
            check(22'({respCurrentEn, rampActive, holdFull}), taken ? 22'h5 : 22'h0);
            repeat (1000) @(posedge ref_clk);
            @(negedge ref_clk);
            check(22'({respCurrentEn, holdFull}), 22'h0);
        end
    endtask : round

    task automatic close_out();
        if (notes.size() != 0) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 22'h0, notes[0]);
        end
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // watchdog: nearly four times the expected run
    initial begin
        #(40 * 60000);
        n_mismatch++;
        close_out();
    end

    initial begin
        void'($urandom(32'h539AC5B4));
        do_reset(4'h0, 1'b0);
        frame(4'h0, 1'b1, 1'b1);
        round(4'h1, 1'b0, 1'b1);
        frame(4'h1, 1'b1, 1'b1);
        frame(4'h1, 1'b0, 1'b1);
        frame(4'h2, 1'b1, 1'b0);
        round(4'h1, 1'b0, 1'b0);
        do_reset(4'h0, 1'b0);
        round(4'h2, 1'b1, 1'b1);
        round(4'h2, 1'b0, 1'b0);
        round(4'h2, 1'b0, 1'b1);
        frame(4'h2, 1'b1, 1'b1);
        do_reset(4'h0, 1'b1);
        round(4'h1, 1'b0, 1'b0);
        do_reset(4'h5, 1'b0);
        round(4'h1, 1'b0, 1'b0);
        frame(4'h5, 1'b1, 1'b1);
        frame(4'h0, 1'b1, 1'b0);
        close_out();
    end
endmodule : tb_daisy_chain_discovery_addressing
